// File: logic/sgc_global_ctrl.sv
// Global control registers: storm threshold, host port, null VLAN ID and LED mode
`timescale 1ns/1ns
module sgc_global_ctrl #(
    parameter int unsigned WIN_FAST = sgc_pkg::WIN_FAST_CYC,
    parameter int unsigned WIN_SLOW = sgc_pkg::WIN_SLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [sgc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [sgc_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [sgc_pkg::DATA_W-1:0] avs_readdata,
    output logic [1:0] avs_response,
    output logic avs_waitrequest,
    // Port 1 status and storm block strobe
    input wire sgc_pkg::sgc_port_status_t p1_status,
    input wire logic p1_block_strobe,
    // Port 2 status and storm block strobe
    input wire sgc_pkg::sgc_port_status_t p2_status,
    input wire logic p2_block_strobe,
    // Port LEDs
    output logic [sgc_pkg::LED_W-1:0] p1_port_led_out,
    output logic [sgc_pkg::LED_W-1:0] p2_port_led_out,
    // Storm verdicts
    output sgc_pkg::sgc_storm_out_t p1_storm,
    output sgc_pkg::sgc_storm_out_t p2_storm,
    // Host port settings
    output logic host_half_duplex,
    output logic host_flow_ctrl_en,
    // VLAN ID path
    input wire logic vid_in_valid,
    input wire logic [sgc_pkg::VID_W-1:0] frame_vid,
    input wire logic [sgc_pkg::VID_W-1:0] port_vid,
    output logic vid_out_valid,
    output logic [sgc_pkg::VID_W-1:0] vlan_ident_out
);
    import sgc_pkg::*;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] STORM_HOST_ADDR = {STORM_HOST_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] RSVD_CTRL_ADDR = {RSVD_CTRL_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] CHIP_LED_ADDR = {CHIP_LED_IDX, 2'b00};

    // Register state
    logic [REG_W-1:0] storm_rate_host_port_ctrl_reg, storm_rate_host_port_ctrl_next;
    logic [REG_W-1:0] switch_global_reserved_ctrl_reg, switch_global_reserved_ctrl_next;
    logic [REG_W-1:0] chip_led_mode_ctrl_reg, chip_led_mode_ctrl_next;

    // Bus answer state
    logic avs_waitrequest_next;
    logic [DATA_W-1:0] avs_readdata_next;
    logic [1:0] avs_response_next;

    // Host and VLAN outputs
    logic host_half_duplex_next;
    logic host_flow_ctrl_en_next;
    logic vid_out_valid_next;
    logic [VID_W-1:0] vlan_ident_out_next;

    // Decoded fields
    logic bus_req;
    logic bus_take;
    logic hit_storm;
    logic hit_rsvd;
    logic hit_led;
    logic hit_any;
    logic [REG_W-1:0] lane_mask;
    logic [REG_W-1:0] read_word;
    logic [THRESH_W-1:0] storm_thresh;
    logic led_mode_sel_hi;
    logic led_mode_sel_lo;
    sgc_led_mode_t led_mode;
    logic null_vid_replace;

    // Merge the enabled byte lanes of a write into the writable bits only
    function automatic logic [REG_W-1:0] merge_write(
        input logic [REG_W-1:0] old_val,
        input logic [REG_W-1:0] wr_val,
        input logic [REG_W-1:0] lanes,
        input logic [REG_W-1:0] wmask
    );
        logic [REG_W-1:0] m;
        m = lanes & wmask;
        return (old_val & ~m) | (wr_val & m);
    endfunction

    // Address decode; only the low 16 bits of each word hold register data
    always_comb begin
        bus_req = avs_read || avs_write;
        bus_take = bus_req && !avs_waitrequest;
        hit_storm = (avs_address == STORM_HOST_ADDR);
        hit_rsvd = (avs_address == RSVD_CTRL_ADDR);
        hit_led = (avs_address == CHIP_LED_ADDR);
        hit_any = hit_storm || hit_rsvd || hit_led;
        lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    end

    // Field extraction from the stored registers
    always_comb begin
        storm_thresh = {storm_rate_host_port_ctrl_reg[RATE_HI_LSB +: RATE_HI_W],
                        storm_rate_host_port_ctrl_reg[RATE_LO_LSB +: 8]};
        null_vid_replace = storm_rate_host_port_ctrl_reg[NULL_VID_BIT];
        led_mode_sel_hi = chip_led_mode_ctrl_reg[LED_SEL_HI_BIT];
        led_mode_sel_lo = chip_led_mode_ctrl_reg[LED_SEL_LO_BIT];
        led_mode = sgc_led_mode_t'({led_mode_sel_hi, led_mode_sel_lo});
    end

    // Read mux; bit 7 of the storm register and the low LED byte are read-only
    always_comb begin
        read_word = '0;
        if (hit_storm) begin
            read_word = storm_rate_host_port_ctrl_reg;
        end else if (hit_rsvd) begin
            read_word = switch_global_reserved_ctrl_reg;
        end else if (hit_led) begin
            read_word = chip_led_mode_ctrl_reg | CHIP_LED_RO;
        end
    end

    // Bus handshake: waitrequest drops for one cycle, a cycle after the request
    // appears, so read data always come from a register
    always_comb begin
        avs_waitrequest_next = !(bus_req && avs_waitrequest);
        avs_readdata_next = avs_readdata;
        avs_response_next = avs_response;
        if (bus_req && avs_waitrequest) begin
            avs_readdata_next = avs_read ? {{(DATA_W - REG_W){1'b0}}, read_word} : '0;
            avs_response_next = hit_any ? RESP_OKAY : RESP_DECODE_ERR;
        end
    end

    // Register writes take effect at the edge where the master sees waitrequest low
    always_comb begin
        storm_rate_host_port_ctrl_next = storm_rate_host_port_ctrl_reg;
        switch_global_reserved_ctrl_next = switch_global_reserved_ctrl_reg;
        chip_led_mode_ctrl_next = chip_led_mode_ctrl_reg;
        if (bus_take && avs_write) begin
            if (hit_storm) begin
                storm_rate_host_port_ctrl_next = merge_write(storm_rate_host_port_ctrl_reg,
                    avs_writedata[REG_W-1:0], lane_mask, STORM_HOST_WMASK);
            end
            if (hit_rsvd) begin
                // Stored as written; software is expected to keep its reset value
                switch_global_reserved_ctrl_next = merge_write(switch_global_reserved_ctrl_reg,
                    avs_writedata[REG_W-1:0], lane_mask, RSVD_CTRL_WMASK);
            end
            if (hit_led) begin
                chip_led_mode_ctrl_next = merge_write(chip_led_mode_ctrl_reg,
                    avs_writedata[REG_W-1:0], lane_mask, CHIP_LED_WMASK);
            end
        end
    end

    // Host port settings leave through a flip-flop, one cycle behind the register
    always_comb begin
        host_half_duplex_next = storm_rate_host_port_ctrl_reg[HALF_DUPLEX_BIT];
        host_flow_ctrl_en_next = storm_rate_host_port_ctrl_reg[FLOW_CTRL_BIT];
    end

    // Null VLAN ID replacement; a null ID is all zero
    always_comb begin
        vid_out_valid_next = vid_in_valid;
        vlan_ident_out_next = vlan_ident_out;
        if (vid_in_valid) begin
            if (null_vid_replace && (frame_vid == '0)) begin
                vlan_ident_out_next = port_vid;
            end else begin
                vlan_ident_out_next = frame_vid;
            end
        end
    end

    // All registers of the block
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            storm_rate_host_port_ctrl_reg <= STORM_HOST_RST;
            switch_global_reserved_ctrl_reg <= RSVD_CTRL_RST;
            chip_led_mode_ctrl_reg <= CHIP_LED_RST;
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            avs_response <= RESP_OKAY;
            host_half_duplex <= 1'b0;
            host_flow_ctrl_en <= 1'b1;
            vid_out_valid <= 1'b0;
            vlan_ident_out <= '0;
        end else begin
            storm_rate_host_port_ctrl_reg <= storm_rate_host_port_ctrl_next;
            switch_global_reserved_ctrl_reg <= switch_global_reserved_ctrl_next;
            chip_led_mode_ctrl_reg <= chip_led_mode_ctrl_next;
            avs_waitrequest <= avs_waitrequest_next;
            avs_readdata <= avs_readdata_next;
            avs_response <= avs_response_next;
            host_half_duplex <= host_half_duplex_next;
            host_flow_ctrl_en <= host_flow_ctrl_en_next;
            vid_out_valid <= vid_out_valid_next;
            vlan_ident_out <= vlan_ident_out_next;
        end
    end

    // Port 1 meter and LEDs; both ports share one threshold and one LED mode
    sgc_port_unit #(
        .WIN_FAST(WIN_FAST),
        .WIN_SLOW(WIN_SLOW)
    ) u_port1 (
        .clk(clk),
        .reset_n(reset_n),
        .led_mode(led_mode),
        .storm_thresh(storm_thresh),
        .status(p1_status),
        .block_strobe(p1_block_strobe),
        .port_led_out(p1_port_led_out),
        .storm_out(p1_storm)
    );

    // Port 2 meter and LEDs
    sgc_port_unit #(
        .WIN_FAST(WIN_FAST),
        .WIN_SLOW(WIN_SLOW)
    ) u_port2 (
        .clk(clk),
        .reset_n(reset_n),
        .led_mode(led_mode),
        .storm_thresh(storm_thresh),
        .status(p2_status),
        .block_strobe(p2_block_strobe),
        .port_led_out(p2_port_led_out),
        .storm_out(p2_storm)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Bus handshake: the answer lasts one cycle and follows a request
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("Waitrequest low for more than one cycle");
    wait_cause_a: assert property (!avs_waitrequest |-> $past(bus_req))
        else $error("Waitrequest dropped with no request");
    decode_err_a: assert property (bus_req && avs_waitrequest && !hit_any
        |=> avs_response == RESP_DECODE_ERR)
        else $error("Unmapped address answered OKAY");

    // Threshold follows a full write of the storm register
    thresh_form_a: assert property (bus_take && avs_write && hit_storm
        && avs_byteenable[1:0] == 2'b11
        |=> storm_thresh == {$past(avs_writedata[2:0]), $past(avs_writedata[15:8])})
        else $error("Storm threshold not formed from written fields");

    // Values seen right after reset release
    reset_vals_a: assert property ($rose(reset_n) |-> storm_thresh == 11'h063
        && !host_half_duplex && host_flow_ctrl_en && led_mode == LED_MODE_LINK_ACT)
        else $error("Wrong values after reset");

    // Host duplex bit reaches its output two edges after the write
    half_dup_a: assert property (bus_take && avs_write && hit_storm
        && avs_byteenable[0] |=> ##1 host_half_duplex == $past(avs_writedata[6], 2))
        else $error("Host duplex output does not follow bit 6");

    // Host flow-control bit reaches its output two edges after the write
    flow_ctrl_a: assert property (bus_take && avs_write && hit_storm
        && avs_byteenable[0] |=> ##1 host_flow_ctrl_en == $past(avs_writedata[5], 2))
        else $error("Host flow control output does not follow bit 5");

    // Null ID replaced only when enabled
    null_vid_a: assert property (vid_in_valid && null_vid_replace && frame_vid == '0
        |=> vlan_ident_out == $past(port_vid))
        else $error("Null VLAN ID not replaced");
    keep_vid_a: assert property (vid_in_valid && !(null_vid_replace && frame_vid == '0)
        |=> vlan_ident_out == $past(frame_vid))
        else $error("VLAN ID altered when it should pass");

    // LED mode select bits come from bits 15 and 9
    led_sel_a: assert property (bus_take && avs_write && hit_led && avs_byteenable[1]
        |=> led_mode == sgc_led_mode_t'({$past(avs_writedata[15]), $past(avs_writedata[9])}))
        else $error("LED mode does not follow bits 15 and 9");

endmodule // sgc_global_ctrl

// File: pkg/sgc_pkg.sv
// Constants and types of the switch global control, storm and LED register block
package sgc_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int IDX_W = 6;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] STORM_HOST_IDX = 6'h06;
    localparam logic [IDX_W-1:0] RSVD_CTRL_IDX = 6'h08;
    localparam logic [IDX_W-1:0] CHIP_LED_IDX = 6'h0a;

    // Field positions
    localparam int RATE_LO_LSB = 8;
    localparam int RATE_HI_LSB = 0;
    localparam int RATE_HI_W = 3;
    localparam int HALF_DUPLEX_BIT = 6;
    localparam int FLOW_CTRL_BIT = 5;
    localparam int NULL_VID_BIT = 3;
    localparam int LED_SEL_HI_BIT = 15;
    localparam int LED_SEL_LO_BIT = 9;

    // Reset values, writable masks and read-only constants
    localparam logic [REG_W-1:0] STORM_HOST_RST = 16'h6320;
    localparam logic [REG_W-1:0] STORM_HOST_WMASK = 16'hff7f;
    localparam logic [REG_W-1:0] RSVD_CTRL_RST = 16'h2400;
    localparam logic [REG_W-1:0] RSVD_CTRL_WMASK = 16'hffff;
    localparam logic [REG_W-1:0] CHIP_LED_RST = 16'h0800;
    localparam logic [REG_W-1:0] CHIP_LED_WMASK = 16'hfe00;
    localparam logic [REG_W-1:0] CHIP_LED_RO = 16'h0035;

    // Avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

    // Storm window timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS = 1_000_000;
    localparam int unsigned WIN_FAST_MS = 67;
    localparam int unsigned WIN_SLOW_MS = 670;
    localparam int unsigned WIN_FAST_CYC = WIN_FAST_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned WIN_SLOW_CYC = WIN_SLOW_MS * NS_PER_MS / CLK_PERIOD_NS;
    localparam int WIN_CNT_W = 30;
    localparam int THRESH_W = 11;
    localparam int VID_W = 12;
    localparam int LED_W = 4;

    // LED mode, in the order of its two-bit select code
    typedef enum logic [1:0] {
        LED_MODE_LINK_ACT,
        LED_MODE_SPEED_SPLIT,
        LED_MODE_SEPARATE,
        LED_MODE_OFF
    } sgc_led_mode_t;

    // Link state reported by one port's PHY
    typedef struct packed {
        logic link;
        logic activity;
        logic full_duplex;
        logic collision;
        logic speed_100;
    } sgc_port_status_t;

    // Storm meter verdicts of one port
    typedef struct packed {
        logic block_pass;
        logic block_drop;
        logic storm_limit;
    } sgc_storm_out_t;

endpackage

// File: logic/sgc_port_unit.sv
// One switch port's storm meter and LED mapper
`timescale 1ns/1ns
module sgc_port_unit #(
    parameter int unsigned WIN_FAST = sgc_pkg::WIN_FAST_CYC,
    parameter int unsigned WIN_SLOW = sgc_pkg::WIN_SLOW_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Configuration
    input wire sgc_pkg::sgc_led_mode_t led_mode,
    input wire logic [sgc_pkg::THRESH_W-1:0] storm_thresh,
    // Port activity
    input wire sgc_pkg::sgc_port_status_t status,
    input wire logic block_strobe,
    // Results
    output logic [sgc_pkg::LED_W-1:0] port_led_out,
    output sgc_pkg::sgc_storm_out_t storm_out
);
    import sgc_pkg::*;

    logic [WIN_CNT_W-1:0] win_cnt_reg, win_cnt_next;
    logic [THRESH_W-1:0] blocks_reg, blocks_next;
    logic speed_reg, speed_next;
    logic [LED_W-1:0] port_led_out_next;
    sgc_storm_out_t storm_out_next;
    logic [WIN_CNT_W-1:0] win_last;
    logic win_end;
    logic link_act;

    // Window length follows the port speed; a speed change restarts the window
    always_comb begin
        win_last = status.speed_100 ? WIN_CNT_W'(WIN_FAST - 1) : WIN_CNT_W'(WIN_SLOW - 1);
        win_end = (win_cnt_reg >= win_last) || (speed_reg != status.speed_100);
        speed_next = status.speed_100;
        win_cnt_next = win_end ? '0 : win_cnt_reg + 1'b1;
        blocks_next = win_end ? '0 : blocks_reg;
        storm_out_next = '0;
        if (block_strobe) begin
            if (blocks_reg < storm_thresh) begin
                storm_out_next.block_pass = 1'b1;
                blocks_next = win_end ? THRESH_W'(1) : blocks_reg + 1'b1;
            end else begin
                storm_out_next.block_drop = 1'b1;
            end
        end
        storm_out_next.storm_limit = (blocks_next >= storm_thresh);
    end

    // LED meaning per mode; link/activity is lit with link and blinks off on traffic
    always_comb begin
        link_act = status.link && !status.activity;
        port_led_out_next = '0;
        unique case (led_mode)
            LED_MODE_LINK_ACT: begin
                port_led_out_next[2] = link_act;
                port_led_out_next[1] = status.full_duplex || status.collision;
                port_led_out_next[0] = status.speed_100;
            end
            LED_MODE_SPEED_SPLIT: begin
                port_led_out_next[2] = link_act && status.speed_100;
                port_led_out_next[1] = link_act && !status.speed_100;
                port_led_out_next[0] = status.full_duplex;
            end
            LED_MODE_SEPARATE: begin
                port_led_out_next[3] = status.activity;
                port_led_out_next[2] = status.link;
                port_led_out_next[1] = status.full_duplex || status.collision;
                port_led_out_next[0] = status.speed_100;
            end
            LED_MODE_OFF: port_led_out_next = '0;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            win_cnt_reg <= '0;
            blocks_reg <= '0;
            speed_reg <= 1'b0;
            port_led_out <= '0;
            storm_out <= '0;
        end else begin
            win_cnt_reg <= win_cnt_next;
            blocks_reg <= blocks_next;
            speed_reg <= speed_next;
            port_led_out <= port_led_out_next;
            storm_out <= storm_out_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    led_off_a: assert property (led_mode == LED_MODE_OFF |=> port_led_out == '0)
        else $error("LED driven in mode 11");
    led_sep_a: assert property (led_mode == LED_MODE_SEPARATE
        |=> port_led_out[3] == $past(status.activity) && port_led_out[2] == $past(status.link))
        else $error("LED3/LED2 wrong in mode 10");
    // A threshold lowered mid-window may leave the count above it, so check the verdict
    over_drop_a: assert property (block_strobe && !win_end && blocks_reg >= storm_thresh
        |=> storm_out.block_drop && !storm_out.block_pass)
        else $error("Block passed over the storm threshold");
    win_len_a: assert property (win_cnt_reg <= WIN_CNT_W'(WIN_SLOW - 1))
        else $error("Window counter ran past the slow window");

endmodule // sgc_port_unit

// File: verif/tb.sv
// Self-checking testbench of the global control, storm and LED register block
`timescale 1ns/1ns
module tb;
    import sgc_pkg::*;
    // Short storm windows keep the run brief; expectations derive from these
    localparam int unsigned WF = 60;
    localparam int unsigned WS = 600;
    logic clk, reset_n, avs_read, avs_write, avs_waitrequest, p1_block_strobe, p2_block_strobe;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable, p1_port_led_out, p2_port_led_out;
    logic [1:0] avs_response, rs;
    sgc_port_status_t p1_status, p2_status;
    sgc_storm_out_t p1_storm, p2_storm;
    logic host_half_duplex, host_flow_ctrl_en, vid_in_valid, vid_out_valid;
    logic [11:0] frame_vid, port_vid, vlan_ident_out;
    int n_errors = 0;
    int n_checks = 0;
    sgc_global_ctrl #(.WIN_FAST(WF), .WIN_SLOW(WS)) u_sgc_global_ctrl (.clk(clk),
        .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_response(avs_response),
        .avs_waitrequest(avs_waitrequest), .p1_status(p1_status),
        .p1_block_strobe(p1_block_strobe), .p2_status(p2_status),
        .p2_block_strobe(p2_block_strobe), .p1_port_led_out(p1_port_led_out),
        .p2_port_led_out(p2_port_led_out), .p1_storm(p1_storm), .p2_storm(p2_storm),
        .host_half_duplex(host_half_duplex), .host_flow_ctrl_en(host_flow_ctrl_en),
        .vid_in_valid(vid_in_valid), .frame_vid(frame_vid), .port_vid(port_vid),
        .vid_out_valid(vid_out_valid), .vlan_ident_out(vlan_ident_out));
    // Free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus access; request held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] be);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= be;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (avs_waitrequest !== 1'b0 && i < 20);
        // Data and response are taken at the edge that samples waitrequest low
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            end_of_test();
        end else begin
            rd = avs_readdata;
            rs = avs_response;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000, 4'h3);
        chk(nm, {16'h0000, e}, rd);
        chk("response", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask
    // Expected LED pattern; link/activity is lit on link and blanks on activity
    function automatic logic [3:0] led_exp(input logic [1:0] c, input sgc_port_status_t s);
        logic la;
        la = s.link & ~s.activity;
        case (c)
            2'h0: return {1'b0, la, s.full_duplex | s.collision, s.speed_100};
            2'h1: return {1'b0, la & s.speed_100, la & ~s.speed_100, s.full_duplex};
            2'h2: return {s.activity, s.link, s.full_duplex | s.collision, s.speed_100};
            default: return 4'h0;
        endcase
    endfunction
    task automatic t_reset();
        rd_chk("storm reg", 8'h18, 16'h6320);
        rd_chk("reserved reg", 8'h20, 16'h2400);
        rd_chk("led reg", 8'h28, 16'h0835);
        chk("half duplex", 32'h0, {31'h0, host_half_duplex});
        chk("flow ctrl", 32'h1, {31'h0, host_flow_ctrl_en});
        bus(1'b1, 8'h18, 16'h01e8, 4'h1);
        rd_chk("lane write", 8'h18, 16'h6368);
        bus(1'b0, 8'h30, 16'h0000, 4'h3);
        chk("unmapped resp", {30'h0, RESP_DECODE_ERR}, {30'h0, rs});
        $display("test reset done");
    endtask
    task automatic vlan_ident(input logic [11:0] f, input logic [11:0] e);
        @(posedge clk);
        vid_in_valid <= 1'b1;
        frame_vid <= f;
        @(posedge clk);
        vid_in_valid <= 1'b0;
        #1;
        chk("vid valid", 32'h1, {31'h0, vid_out_valid});
        chk("vid out", {20'h0, e}, {20'h0, vlan_ident_out});
    endtask
    task automatic t_host_vid();
        bus(1'b1, 8'h18, 16'h63c8, 4'h3);
        rd_chk("storm ro bit", 8'h18, 16'h6348);
        chk("half duplex", 32'h1, {31'h0, host_half_duplex});
        chk("flow ctrl", 32'h0, {31'h0, host_flow_ctrl_en});
        vlan_ident(12'h000, 12'habc);
        vlan_ident(12'h005, 12'h005);
        bus(1'b1, 8'h18, 16'h6320, 4'h3);
        vlan_ident(12'h000, 12'h000);
        chk("half duplex", 32'h0, {31'h0, host_half_duplex});
        chk("flow ctrl", 32'h1, {31'h0, host_flow_ctrl_en});
        $display("test host and vid done");
    endtask
    task automatic t_led();
        sgc_port_status_t st [2];
        st[0] = 5'b10101;
        st[1] = 5'b01010;
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h28, 16'h0800 | (16'(c >> 1) << 15) | (16'(c & 1) << 9), 4'h3);
            for (int j = 0; j < 2; j++) begin
                @(posedge clk);
                p1_status <= st[j];
                p2_status <= st[1 - j];
                repeat (2) @(posedge clk);
                #1;
                chk("p1 led", {28'h0, led_exp(2'(c), st[j])}, {28'h0, p1_port_led_out});
                chk("p2 led", {28'h0, led_exp(2'(c), st[1 - j])}, {28'h0, p2_port_led_out});
            end
        end
        rd_chk("led readback", 8'h28, 16'h8a35);
        $display("test led done");
    endtask
    task automatic strobe(input logic e);
        @(posedge clk);
        p1_block_strobe <= 1'b1;
        p2_block_strobe <= 1'b1;
        @(posedge clk);
        p1_block_strobe <= 1'b0;
        p2_block_strobe <= 1'b0;
        #1;
        chk("p1 pass", {31'h0, e}, {31'h0, p1_storm.block_pass});
        chk("p2 pass", {31'h0, e}, {31'h0, p2_storm.block_pass});
        chk("p2 drop", {31'h0, ~e}, {31'h0, p2_storm.block_drop});
    endtask
    task automatic set_speed(input logic s);
        @(posedge clk);
        p1_status <= {4'b1000, s};
        p2_status <= {4'b1000, s};
    endtask
    task automatic t_storm();
        int np, nd;
        np = 0;
        nd = 0;
        set_speed(1'b1);
        bus(1'b1, 8'h18, 16'h0221, 4'h3);
        set_speed(1'b0);
        // Both ports see the same burst so their counts stay alike
        @(posedge clk);
        p1_block_strobe <= 1'b1;
        p2_block_strobe <= 1'b1;
        for (int i = 0; i < 260; i++) begin
            @(posedge clk);
            if (i == 258) begin
                p1_block_strobe <= 1'b0;
                p2_block_strobe <= 1'b0;
            end
            #1;
            np += p1_storm.block_pass;
            nd += p1_storm.block_drop;
        end
        chk("passed blocks", 32'd258, np);
        chk("dropped blocks", 32'd1, nd);
        chk("p1 limit", 32'h1, {31'h0, p1_storm.storm_limit});
        chk("p2 limit", 32'h1, {31'h0, p2_storm.storm_limit});
        repeat (320) @(posedge clk);
        strobe(1'b0);
        // Slow window restarted with the speed change and closes 600 edges later
        repeat (18) @(posedge clk);
        strobe(1'b1);
        chk("p1 limit", 32'h0, {31'h0, p1_storm.storm_limit});
        bus(1'b1, 8'h18, 16'h0120, 4'h3);
        set_speed(1'b1);
        strobe(1'b1);
        strobe(1'b0);
        repeat (45) @(posedge clk);
        strobe(1'b0);
        repeat (15) @(posedge clk);
        strobe(1'b1);
        $display("test storm done");
    endtask
    // Main sequence
    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, p1_block_strobe, p2_block_strobe, vid_in_valid} = 5'h00;
        avs_address = 8'h00;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'h3;
        p1_status = 5'h00;
        p2_status = 5'h00;
        frame_vid = 12'h000;
        port_vid = 12'habc;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_host_vid();
        t_led();
        t_storm();
        end_of_test();
    end
endmodule // tb
